// ### tcr_regs.sv
`timescale 1ns/1ps

// What this block does
// - counter split into high and low bytes
// - counter low-byte read returns the live count
// - counter access goes through high-byte latch
// - one latch shared by all 16-bit registers
// - counter write blocks next-tick compare match
// - each compare value checked every count
// - compare writes commit both bytes together
// - compare A split into high and low bytes
// - compare B split into high and low bytes
// - match flag set one tick after equality
module tcr_regs
  import tcr_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_b,
  // timer tick from prescaler
  input  wire logic        count_tick,
  // register port
  input  wire logic [7:0]  addr,
  input  wire logic [7:0]  wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic      [7:0]  rdata,
  // flag clear, one cycle per bit
  input  wire logic        clear_a,
  input  wire logic        clear_b,
  // results
  output logic      [15:0] timer_count_value,
  output logic      [15:0] compare_a_value,
  output logic      [15:0] compare_b_value,
  output logic             match_a_flag,
  output logic             match_b_flag,
  output tcr_match_t       match_pulse
);

  // ==========================================================================
  // decode
  tcr_bus_req_t req;
  logic [7:0]   hold_byte;
  logic         block_next;
  logic         eq_a_d;
  logic         eq_b_d;

  assign req = '{addr: addr, wdata: wdata, wr: wr, rd: rd};

  function automatic logic hit(input logic [7:0] a, input logic [7:0] b);
    hit = (a == b);
  endfunction : hit

  wire w_cnt_lo = req.wr && hit(req.addr, ADDR_CNT_LO);
  wire w_cnt_hi = req.wr && hit(req.addr, ADDR_CNT_HI);
  wire w_a_lo   = req.wr && hit(req.addr, ADDR_CMP_A_LO);
  wire w_a_hi   = req.wr && hit(req.addr, ADDR_CMP_A_HI);
  wire w_b_lo   = req.wr && hit(req.addr, ADDR_CMP_B_LO);
  wire w_b_hi   = req.wr && hit(req.addr, ADDR_CMP_B_HI);
  wire r_cnt_lo = req.rd && hit(req.addr, ADDR_CNT_LO);
  wire r_cnt_hi = req.rd && hit(req.addr, ADDR_CNT_HI);
  wire r_a_lo   = req.rd && hit(req.addr, ADDR_CMP_A_LO);
  wire r_a_hi   = req.rd && hit(req.addr, ADDR_CMP_A_HI);
  wire r_b_lo   = req.rd && hit(req.addr, ADDR_CMP_B_LO);
  wire r_b_hi   = req.rd && hit(req.addr, ADDR_CMP_B_HI);

  // high-byte writes only fill the shared latch; the low write commits both
  wire        any_hi_wr  = w_cnt_hi || w_a_hi || w_b_hi;
  wire [15:0] wr_word    = {hold_byte, req.wdata};

  // ==========================================================================
  // counter and compare storage
  wire [15:0] cnt_inc    = timer_count_value + 16'h0001;
  wire [15:0] next_count = w_cnt_lo ? wr_word :
                           (count_tick ? cnt_inc : timer_count_value);
  wire [15:0] next_cmp_a = w_a_lo ? wr_word : compare_a_value;
  wire [15:0] next_cmp_b = w_b_lo ? wr_word : compare_b_value;

  // low-byte read snapshots the high byte so a later high read is coherent
  wire [7:0] next_hold =
    any_hi_wr ? req.wdata :
    r_cnt_lo  ? timer_count_value[15:8] :
    r_a_lo    ? compare_a_value[15:8] :
    r_b_lo    ? compare_b_value[15:8] : hold_byte;

  wire [7:0] next_rdata =
    r_cnt_lo ? timer_count_value[7:0] :
    r_a_lo   ? compare_a_value[7:0] :
    r_b_lo   ? compare_b_value[7:0] :
    (r_cnt_hi || r_a_hi || r_b_hi) ? hold_byte : RST_BYTE;

  // ==========================================================================
  // compare
  // equality is registered per tick, flagged on the following tick
  wire eq_a = (timer_count_value == compare_a_value);
  wire eq_b = (timer_count_value == compare_b_value);
  wire next_block = w_cnt_lo ? 1'b1 : (count_tick ? 1'b0 : block_next);
  wire set_a = count_tick && eq_a_d && !block_next;
  wire set_b = count_tick && eq_b_d && !block_next;
  // the tick right after a counter write must not record the new-value
  // equality either, or the blocked match would only be delayed a tick
  wire next_eq_a = count_tick ? (eq_a && !block_next) : eq_a_d;
  wire next_eq_b = count_tick ? (eq_b && !block_next) : eq_b_d;
  // set beats a simultaneous clear so no event is lost
  wire next_flag_a = set_a || (match_a_flag && !clear_a);
  wire next_flag_b = set_b || (match_b_flag && !clear_b);

  // ==========================================================================
  // registers
  // counter
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      timer_count_value <= RST_VALUE16;
    end else begin
      timer_count_value <= next_count;
    end
  end

  // compare channel A
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      compare_a_value <= RST_VALUE16;
    end else begin
      compare_a_value <= next_cmp_a;
    end
  end

  // compare channel B
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      compare_b_value <= RST_VALUE16;
    end else begin
      compare_b_value <= next_cmp_b;
    end
  end

  // shared high-byte latch
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      hold_byte <= RST_BYTE;
    end else begin
      hold_byte <= next_hold;
    end
  end

  // read data stands for one cycle only
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      rdata <= RST_BYTE;
    end else begin
      rdata <= next_rdata;
    end
  end

  // match blocking and registered equality
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      block_next <= 1'b0;
      eq_a_d     <= 1'b0;
      eq_b_d     <= 1'b0;
    end else begin
      block_next <= next_block;
      eq_a_d     <= next_eq_a;
      eq_b_d     <= next_eq_b;
    end
  end

  // sticky flags and one-cycle pulses
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      match_a_flag <= 1'b0;
      match_b_flag <= 1'b0;
      match_pulse  <= '0;
    end else begin
      match_a_flag <= next_flag_a;
      match_b_flag <= next_flag_b;
      match_pulse  <= '{match_a: set_a, match_b: set_b};
    end
  end

  // ==========================================================================
  // assertions
  cnt_lo_commit_a : assert property (@(posedge clk) disable iff (!rst_b)
    w_cnt_lo |=> timer_count_value == {$past(hold_byte), $past(wdata)})
    else $error("counter low write did not commit both bytes");
  cnt_hi_hold_a : assert property (@(posedge clk) disable iff (!rst_b)
    (w_cnt_hi && !count_tick) |=> $stable(timer_count_value))
    else $error("counter high write changed count directly");
  shared_latch_a : assert property (@(posedge clk) disable iff (!rst_b)
    any_hi_wr |=> hold_byte == $past(wdata))
    else $error("high write did not fill shared latch");
  cmp_a_commit_a : assert property (@(posedge clk) disable iff (!rst_b)
    w_a_lo |=> compare_a_value == {$past(hold_byte), $past(wdata)})
    else $error("compare A low write wrong");
  cmp_b_commit_a : assert property (@(posedge clk) disable iff (!rst_b)
    w_b_lo |=> compare_b_value == {$past(hold_byte), $past(wdata)})
    else $error("compare B low write wrong");
  cmp_a_hi_read_a : assert property (@(posedge clk) disable iff (!rst_b)
    (r_a_lo ##1 r_a_hi && !any_hi_wr) |=> rdata == $past(compare_a_value[15:8], 2))
    else $error("compare A high read not latched");
  cnt_lo_read_a : assert property (@(posedge clk) disable iff (!rst_b)
    r_cnt_lo |=> rdata == $past(timer_count_value[7:0]))
    else $error("counter low read wrong");
  hi_read_latch_a : assert property (@(posedge clk) disable iff (!rst_b)
    (r_cnt_lo ##1 r_cnt_hi) |=> rdata == $past(timer_count_value[15:8], 2))
    else $error("counter high read not latched");
  match_block_a : assert property (@(posedge clk) disable iff (!rst_b)
    (count_tick && block_next) |=> !match_pulse.match_a && !match_pulse.match_b && !eq_a_d && !eq_b_d)
    else $error("match not blocked after counter write");
  flag_timing_a : assert property (@(posedge clk) disable iff (!rst_b)
    (count_tick && eq_a_d && !block_next) |=> match_a_flag && match_pulse.match_a)
    else $error("match A flag not set one tick after equality");
  flag_b_cause_a : assert property (@(posedge clk) disable iff (!rst_b)
    $rose(match_b_flag) |-> $past(count_tick && eq_b_d))
    else $error("match B flag without equality");


  block_arm_a : assert property (@(posedge clk) disable iff (!rst_b)
    w_cnt_lo |=> block_next)
    else $error("counter write did not arm match blocking");

  cnt_tick_inc_a : assert property (@(posedge clk) disable iff (!rst_b)
    (count_tick && !w_cnt_lo) |=> timer_count_value == $past(timer_count_value) + 16'h0001)
    else $error("counter did not advance on tick");

  cnt_idle_a : assert property (@(posedge clk) disable iff (!rst_b)
    (!count_tick && !w_cnt_lo) |=> $stable(timer_count_value))
    else $error("counter moved without tick or write");

  cmp_a_hold_a : assert property (@(posedge clk) disable iff (!rst_b)
    !w_a_lo |=> $stable(compare_a_value))
    else $error("compare A changed without low write");

  cmp_b_hold_a : assert property (@(posedge clk) disable iff (!rst_b)
    !w_b_lo |=> $stable(compare_b_value))
    else $error("compare B changed without low write");

  rd_idle_a : assert property (@(posedge clk) disable iff (!rst_b)
    !rd |=> rdata == RST_BYTE)
    else $error("read data not idle without read");

  lo_read_latch_a : assert property (@(posedge clk) disable iff (!rst_b)
    r_cnt_lo |=> hold_byte == $past(timer_count_value[15:8]))
    else $error("counter low read did not latch high byte");

  b_lo_read_a : assert property (@(posedge clk) disable iff (!rst_b)
    r_b_lo |=> rdata == $past(compare_b_value[7:0]))
    else $error("compare B low read wrong");

  pulse_flag_a : assert property (@(posedge clk) disable iff (!rst_b)
    match_pulse.match_b |-> match_b_flag)
    else $error("match B pulse without flag");

  set_wins_a : assert property (@(posedge clk) disable iff (!rst_b)
    (set_b && clear_b) |=> match_b_flag)
    else $error("clear beat a simultaneous set");

  cov_match_a  : cover property (@(posedge clk) disable iff (!rst_b) match_pulse.match_a);
  cov_blocked  : cover property (@(posedge clk) disable iff (!rst_b) count_tick && block_next && eq_a);
  cov_match_b  : cover property (@(posedge clk) disable iff (!rst_b) match_pulse.match_b);
  cov_word_wr  : cover property (@(posedge clk) disable iff (!rst_b) w_cnt_hi ##1 w_cnt_lo);
  cov_set_clr  : cover property (@(posedge clk) disable iff (!rst_b) set_a && clear_a);

endmodule : tcr_regs

// ### tcr_pkg.sv
package tcr_pkg;

  // ==========================================================================
  // register map
  localparam logic [7:0] ADDR_CMP_B_LO = 8'h24;
  localparam logic [7:0] ADDR_CMP_B_HI = 8'h25;
  localparam logic [7:0] ADDR_CMP_A_LO = 8'h26;
  localparam logic [7:0] ADDR_CMP_A_HI = 8'h27;
  localparam logic [7:0] ADDR_CNT_LO   = 8'h28;
  localparam logic [7:0] ADDR_CNT_HI   = 8'h29;

  // ==========================================================================
  // reset values
  localparam logic [15:0] RST_VALUE16 = 16'h0000;
  localparam logic [7:0]  RST_BYTE    = 8'h00;

  // ==========================================================================
  // carriers
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } tcr_bus_req_t;

  typedef struct packed {
    logic match_a;
    logic match_b;
  } tcr_match_t;

endpackage : tcr_pkg

// ### tcr_regs_tb.sv
`timescale 1ns/1ps
module tcr_regs_tb;
  import tcr_pkg::*;
  // ==========================================================================
  // stimulus and observed outputs
  logic        clk         = 1'b0;
  logic        rst_b       = 1'b0;
  logic        count_tick  = 1'b0;
  logic [7:0]  addr        = 8'h00;
  logic [7:0]  wdata       = 8'h00;
  logic        wr          = 1'b0;
  logic        rd          = 1'b0;
  logic        clear_a     = 1'b0;
  logic        clear_b     = 1'b0;
  logic [7:0]  rdata;
  logic [15:0] cnt_v;
  logic [15:0] cmp_a_v;
  logic [15:0] cmp_b_v;
  logic        flag_a;
  logic        flag_b;
  tcr_match_t  pulse;
  logic [7:0]  rv;
  int          error_cnt   = 0;
  int          comparisons = 0;

  always #10 clk = ~clk;

  tcr_regs DUT (.clk(clk), .rst_b(rst_b), .count_tick(count_tick), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .clear_a(clear_a), .clear_b(clear_b), .timer_count_value(cnt_v),
    .compare_a_value(cmp_a_v), .compare_b_value(cmp_b_v), .match_a_flag(flag_a), .match_b_flag(flag_b),
    .match_pulse(pulse));

  // ==========================================================================
  // access tasks: strobes rise and fall on rising edges only
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
    #1;
  endtask : wr_reg

  task automatic rd_reg(input logic [7:0] a);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    #1;
    rv = rdata;
  endtask : rd_reg

  // high byte first: it only loads the shared latch
  task automatic wr16(input logic [7:0] hi, input logic [15:0] v);
    wr_reg(hi, v[15:8]);
    wr_reg(hi - 8'h01, v[7:0]);
  endtask : wr16

  task automatic tick();
    @(posedge clk);
    count_tick <= 1'b1;
    @(posedge clk);
    count_tick <= 1'b0;
    #1;
  endtask : tick

  // start one below the compare value so the blocked tick is harmless
  task automatic match_run(input logic [15:0] start, input tcr_match_t exp);
    wr16(ADDR_CNT_HI, start);
    repeat (2) tick();
    chk("early pulse", 16'h0000, {14'h0000, pulse});
    tick();
    chk("match pulse", {14'h0000, exp}, {14'h0000, pulse});
    tick();
    chk("pulse width", 16'h0000, {14'h0000, pulse});
  endtask : match_run

  task automatic end_sim();
    $display("comparisons %0d error_cnt %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : end_sim

  // ==========================================================================
  // main sequence
  initial begin
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    wr_reg(8'h2A, 8'hFF);
    for (int a = 8'h24; a <= 8'h2A; a++) begin
      rd_reg(8'(a));
      chk("reset or unmapped read", 16'h0000, {8'h00, rv});
    end
    wr16(ADDR_CNT_HI, 16'h12FF);
    chk("count write", 16'h12FF, cnt_v);
    rd_reg(ADDR_CNT_LO);
    chk("count low", 16'h00FF, {8'h00, rv});
    tick();
    chk("count after tick", 16'h1300, cnt_v);
    rd_reg(ADDR_CNT_HI);
    chk("latched count high", 16'h0012, {8'h00, rv});
    wr_reg(ADDR_CMP_A_HI, 8'h55);
    wr_reg(ADDR_CMP_B_HI, 8'h66);
    wr_reg(ADDR_CMP_A_LO, 8'h01);
    chk("shared latch commit", 16'h6601, cmp_a_v);
    chk("high write alone", 16'h0000, cmp_b_v);
    wr16(ADDR_CMP_B_HI, 16'h0020);
    chk("compare b", 16'h0020, cmp_b_v);
    wr16(ADDR_CMP_A_HI, 16'h0010);
    rd_reg(ADDR_CMP_A_LO);
    chk("compare a low", 16'h0010, {8'h00, rv});
    rd_reg(ADDR_CMP_A_HI);
    chk("compare a high", 16'h0000, {8'h00, rv});
    match_run(16'h000F, 2'b10);
    chk("flag a set", 16'h0001, {15'h0000, flag_a});
    match_run(16'h001F, 2'b01);
    chk("flag b set", 16'h0001, {15'h0000, flag_b});
    @(posedge clk);
    clear_a <= 1'b1;
    clear_b <= 1'b1;
    @(posedge clk);
    clear_a <= 1'b0;
    clear_b <= 1'b0;
    #1;
    chk("flags cleared", 16'h0000, {14'h0000, flag_a, flag_b});
    wr16(ADDR_CNT_HI, 16'h0010);
    repeat (4) tick();
    chk("blocked match", 16'h0000, {14'h0000, flag_a, flag_b});
    end_sim();
  end

  initial begin
    repeat (5000) @(posedge clk);
    error_cnt++;
    end_sim();
  end
endmodule : tcr_regs_tb
